// ==== rsft_far_end.sv ====
`timescale 1ns/1ps
// ***************************************************************
// far side: four supplies and the shared error line
// ***************************************************************
module rsft_far_end
#(
	parameter int LAG = 3
)
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] rail_enable_outputs,
	input  wire logic       err_line_oe_n,
	input  wire logic       err_line_out,
	input  wire logic [3:0] kill,
	input  wire logic       ext_pull,
	output logic      [3:0] rail_sense_inputs,
	output logic            err_line_in
);
	genvar g;
	// a supply reaches its level LAG cycles after enable; a killed one never
	for (g = 0; g < 4; g++)
	begin : g_rail
		logic [3:0] age_r;
		logic [3:0] age_nxt;
		assign age_nxt = !rail_enable_outputs[g] ? 4'h0
			: (age_r == 4'hf ? age_r : age_r + 4'h1);
		always_ff @(posedge core_clk or negedge rst_n)
			if (!rst_n)
				age_r <= 4'h0;
			else
				age_r <= age_nxt;
		// disabled rail discharges at once, so the sense goes low
		assign rail_sense_inputs[g] = rail_enable_outputs[g] && !kill[g]
			&& age_r >= 4'(LAG);
	end

	// pulled-up open-drain line: low while any party pulls it
	assign err_line_in = !ext_pull && (err_line_oe_n || err_line_out);
endmodule

// ==== rsft_pkg.sv ====
package rsft_pkg;

	// ***************************************************************
	// sizes and timing
	// ***************************************************************
	localparam int unsigned NUM_RAILS     = 4;
	localparam int unsigned TMR_W         = 32;
	localparam int unsigned CLK_HZ        = 125_000_000;
	// delay per microfarad of timing capacitance, in ms (0.1 s / uF)
	localparam int unsigned MS_PER_UF     = 100;
	// supported delay span, in ms, and smallest capacitor, in nF
	localparam int unsigned DLY_MIN_MS    = 1;
	localparam int unsigned DLY_MAX_MS    = 220;
	localparam int unsigned CAP_MIN_NF    = 10;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
	localparam int unsigned DLY_MIN_CYC   = DLY_MIN_MS * CYC_PER_MS;
	localparam int unsigned DLY_MAX_CYC   = DLY_MAX_MS * CYC_PER_MS;
	// capacitor absent: a few microseconds
	localparam int unsigned NOCAP_US      = 3;
	localparam int unsigned NOCAP_CYC     = NOCAP_US * (CLK_HZ / 1_000_000);
	// fault hold time and request low qualify time (defaults, in us)
	localparam int unsigned HOLD_US       = 500;
	localparam int unsigned HOLD_CYC      = HOLD_US * (CLK_HZ / 1_000_000);
	localparam int unsigned QUAL_US       = 10;
	localparam int unsigned QUAL_CYC      = QUAL_US * (CLK_HZ / 1_000_000);

	// ***************************************************************
	// sequencer states
	// ***************************************************************
	typedef enum logic [3:0]
	{
		RSFT_FLT_ENTRY,
		RSFT_FLT_RELEASE,
		RSFT_LINE_WAIT,
		RSFT_IDLE,
		RSFT_UP_STEP,
		RSFT_UP_SETTLE,
		RSFT_RAILS_ON,
		RSFT_DN_STEP,
		RSFT_DN_LAST
	} rsft_state_t;

endpackage

// ==== rsft_seq.sv ====
`timescale 1ns/1ps
// Functional notes
// - watch rails, requests, error line in idle, up, on and down states
// - rail not up by settle end faults
// - settled rail dropping during power-up faults
// - enabled rail dropping during power-down faults
// - falling request edge faults in idle/up
// - rising request edge faults in down/on
// - fault: rails, finished, error line low
// - hold entry state for fault hold time
// - qualified low request skips release wait
// - error low held, extended while request high
// - release: request low frees error line
// - wait for error line high, then idle
// - combined variant has three step timers
// - first step timer before rail one, after
// - up step runs settle end to enable
// - down step spaces successive rail disables
// - one shared settle window timer
// - delay started by sequencer, programmed length
// - supported delays 1 ms to 220 ms
// - no capacitor gives microsecond delay
// - allow recovery time between timer uses (only flagged on timer_recovering; the sequencer does not wait)
// - start in error entry state
module rsft_seq
#(
	parameter bit                         COMBINED  = 1'b0,
	parameter logic [rsft_pkg::TMR_W-1:0] HOLD_CYC  =
		rsft_pkg::TMR_W'(rsft_pkg::HOLD_CYC),
	parameter logic [rsft_pkg::TMR_W-1:0] QUAL_CYC  =
		rsft_pkg::TMR_W'(rsft_pkg::QUAL_CYC),
	parameter logic [rsft_pkg::TMR_W-1:0] RECOV_CYC =
		rsft_pkg::TMR_W'(rsft_pkg::NOCAP_CYC)
)
(
	input  wire logic                         core_clk,
	input  wire logic                         rst_n,
	input  wire logic [3:0]                   rail_sense_inputs,
	input  wire logic                         req_rise_in,
	input  wire logic                         req_fall_in,
	input  wire logic                         err_line_in,
	input  wire logic [rsft_pkg::TMR_W-1:0]   step_dly_0,
	input  wire logic [rsft_pkg::TMR_W-1:0]   step_dly_1,
	input  wire logic [rsft_pkg::TMR_W-1:0]   step_dly_2,
	input  wire logic [rsft_pkg::TMR_W-1:0]   step_dly_3,
	input  wire logic [rsft_pkg::TMR_W-1:0]   settle_dly,
	output logic      [3:0]                   rail_enable_outputs,
	output logic                              chain_finished_output,
	output logic                              err_line_oe_n,
	output logic                              err_line_out,
	output logic      [3:0]                   fault_cause,
	output logic                              timer_recovering,
	output logic                              delay_out_of_range
);

	// ***************************************************************
	// input synchronisers and edge events
	// ***************************************************************
	localparam int unsigned NS = 7;

	logic [NS-1:0] raw_in;
	logic [NS-1:0] s_lvl;
	logic [NS-1:0] s_rise;
	logic [NS-1:0] s_fall;
	logic [NS-1:0] s_rst;

	assign raw_in = {err_line_in, req_fall_in, req_rise_in, rail_sense_inputs};
	// error line idles high, requests and rails idle low
	assign s_rst  = {1'b1, 1'b0, 1'b0, 4'h0};

	rsft_sync #(.W(NS)) u_sync
	(
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.async_in (raw_in),
		.rst_val  (s_rst),
		.sync_out (s_lvl),
		.rise_out (s_rise),
		.fall_out (s_fall)
	);

	logic [3:0] rail_ok;
	logic       up_lvl;
	logic       up_rise;
	logic       dn_fall;
	logic       err_lvl;
	logic       err_fall;

	assign rail_ok  = s_lvl[3:0];
	// combined variant: the rising input carries both directions
	assign up_lvl   = s_lvl[4];
	assign up_rise  = s_rise[4];
	assign dn_fall  = COMBINED ? s_fall[4] : s_fall[5];
	assign err_lvl  = s_lvl[6];
	assign err_fall = s_fall[6];

	// ***************************************************************
	// state and step index
	// ***************************************************************
	rsft_pkg::rsft_state_t st_r;
	rsft_pkg::rsft_state_t st_nxt;
	logic [1:0]            idx_r;
	logic [1:0]            idx_nxt;
	logic [3:0]            en_r;
	logic [3:0]            en_nxt;
	logic                  drive_err_r;
	logic                  drive_err_nxt;
	logic                  err_self_r;

	// ***************************************************************
	// timers: one per step plus the shared settle window
	// ***************************************************************
	logic [rsft_pkg::TMR_W-1:0] step_lim [4];
	logic [3:0]                 step_run;
	logic [3:0]                 step_done;
	logic                       settle_run;
	logic                       settle_done;
	logic                       step_active;

	assign step_lim[0] = step_dly_0;
	assign step_lim[1] = step_dly_1;
	assign step_lim[2] = step_dly_2;
	assign step_lim[3] = step_dly_3;

	assign step_active = (st_r == rsft_pkg::RSFT_UP_STEP)
		|| (st_r == rsft_pkg::RSFT_DN_STEP)
		|| (st_r == rsft_pkg::RSFT_DN_LAST);

	// combined variant never runs the first step timer
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_step
			assign step_run[gi] = step_active && (idx_r == 2'(gi))
				&& !(COMBINED && gi == 0);
			rsft_timer u_tmr
			(
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.run      (step_run[gi]),
				.limit    (step_lim[gi]),
				.done     (step_done[gi])
			);
		end
	endgenerate

	assign settle_run = (st_r == rsft_pkg::RSFT_UP_SETTLE);

	rsft_timer u_settle
	(
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.run      (settle_run),
		.limit    (settle_dly),
		.done     (settle_done)
	);

	logic step_fin;
	assign step_fin = (COMBINED && idx_r == 2'd0) ? 1'b1 : step_done[idx_r];

	// ***************************************************************
	// fault hold and request-low qualify counters
	// ***************************************************************
	logic [rsft_pkg::TMR_W-1:0] hold_r;
	logic [rsft_pkg::TMR_W-1:0] qual_r;
	logic                       hold_done;
	logic                       req_qual;

	assign hold_done = (hold_r >= HOLD_CYC);
	assign req_qual  = (qual_r >= QUAL_CYC);

	// qualify counter runs while the rising request stays low
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hold_r <= '0;
			qual_r <= '0;
		end
		else
		begin
			hold_r <= (st_r != rsft_pkg::RSFT_FLT_ENTRY) ? '0 :
				(hold_done ? hold_r : hold_r + 1'b1);
			qual_r <= up_lvl ? '0 : (req_qual ? qual_r : qual_r + 1'b1);
		end
	end

	// ***************************************************************
	// fault detection
	// ***************************************************************
	logic [3:0] settled_r;
	logic       f_settle;
	logic       f_uv_up;
	logic       f_uv_dn;
	logic       f_edge;
	logic       f_ext;
	logic       in_up;
	logic       in_dn;
	logic       any_fault;

	assign in_up   = (st_r == rsft_pkg::RSFT_UP_STEP)
		|| (st_r == rsft_pkg::RSFT_UP_SETTLE);
	assign in_dn   = (st_r == rsft_pkg::RSFT_DN_STEP)
		|| (st_r == rsft_pkg::RSFT_DN_LAST);
	assign f_settle = settle_done && !rail_ok[idx_r];
	assign f_uv_up  = (in_up || st_r == rsft_pkg::RSFT_RAILS_ON)
		&& |(settled_r & ~rail_ok);
	assign f_uv_dn  = in_dn && |(en_r & ~rail_ok);
	assign f_edge   = (dn_fall && (in_up || st_r == rsft_pkg::RSFT_IDLE))
		|| (up_rise && (in_dn || st_r == rsft_pkg::RSFT_RAILS_ON));
	// own drive low is not mistaken for another party's fault
	assign f_ext    = err_fall && !err_self_r;
	assign any_fault = (f_settle || f_uv_up || f_uv_dn || f_edge || f_ext)
		&& (in_up || in_dn || st_r == rsft_pkg::RSFT_IDLE
		|| st_r == rsft_pkg::RSFT_RAILS_ON);

	// ***************************************************************
	// next-state logic
	// ***************************************************************
	always_comb
	begin
		st_nxt        = st_r;
		idx_nxt       = idx_r;
		en_nxt        = en_r;
		drive_err_nxt = drive_err_r;
		if (any_fault)
		begin
			st_nxt        = rsft_pkg::RSFT_FLT_ENTRY;
			en_nxt        = 4'h0;
			drive_err_nxt = 1'b1;
		end
		else
		begin
			case (st_r)
				rsft_pkg::RSFT_FLT_ENTRY:
				begin
					en_nxt        = 4'h0;
					drive_err_nxt = 1'b1;
					if (hold_done)
					begin
						if (req_qual)
						begin
							st_nxt        = rsft_pkg::RSFT_LINE_WAIT;
							drive_err_nxt = 1'b0;
						end
						else
							st_nxt = rsft_pkg::RSFT_FLT_RELEASE;
					end
				end
				rsft_pkg::RSFT_FLT_RELEASE:
				begin
					if (!up_lvl)
					begin
						st_nxt        = rsft_pkg::RSFT_LINE_WAIT;
						drive_err_nxt = 1'b0;
					end
				end
				rsft_pkg::RSFT_LINE_WAIT:
				begin
					if (err_lvl && !err_self_r)
						st_nxt = rsft_pkg::RSFT_IDLE;
				end
				rsft_pkg::RSFT_IDLE:
				begin
					if (up_rise)
					begin
						st_nxt  = rsft_pkg::RSFT_UP_STEP;
						idx_nxt = 2'd0;
					end
				end
				rsft_pkg::RSFT_UP_STEP:
				begin
					if (step_fin)
					begin
						en_nxt[idx_r] = 1'b1;
						st_nxt        = rsft_pkg::RSFT_UP_SETTLE;
					end
				end
				rsft_pkg::RSFT_UP_SETTLE:
				begin
					if (settle_done)
					begin
						if (idx_r == 2'd3)
							st_nxt = rsft_pkg::RSFT_RAILS_ON;
						else
						begin
							idx_nxt = idx_r + 2'd1;
							st_nxt  = rsft_pkg::RSFT_UP_STEP;
						end
					end
				end
				rsft_pkg::RSFT_RAILS_ON:
				begin
					if (dn_fall)
					begin
						en_nxt[3] = 1'b0;
						idx_nxt   = 2'd3;
						st_nxt    = rsft_pkg::RSFT_DN_STEP;
					end
				end
				rsft_pkg::RSFT_DN_STEP:
				begin
					if (step_fin)
					begin
						idx_nxt         = idx_r - 2'd1;
						en_nxt[idx_nxt] = 1'b0;
						if (idx_r == 2'd1)
							st_nxt = rsft_pkg::RSFT_DN_LAST;
					end
				end
				rsft_pkg::RSFT_DN_LAST:
				begin
					if (step_fin)
						st_nxt = rsft_pkg::RSFT_IDLE;
				end
				default:
					st_nxt = rsft_pkg::RSFT_FLT_ENTRY;
			endcase
		end
	end

	// ***************************************************************
	// state registers; reset lands in the fault entry state
	// ***************************************************************
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r        <= rsft_pkg::RSFT_FLT_ENTRY;
			idx_r       <= 2'd0;
			en_r        <= 4'h0;
			drive_err_r <= 1'b1;
			err_self_r  <= 1'b1;
		end
		else
		begin
			st_r        <= st_nxt;
			idx_r       <= idx_nxt;
			en_r        <= en_nxt;
			drive_err_r <= drive_err_nxt;
			// own drive echo lasts through the synchroniser delay
			err_self_r  <= drive_err_r || drive_err_nxt || !err_lvl
				&& err_self_r;
		end
	end

	// a rail counts as settled once its window passed while enabled
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			settled_r <= 4'h0;
		else if (st_nxt == rsft_pkg::RSFT_FLT_ENTRY
			|| st_nxt == rsft_pkg::RSFT_IDLE)
			settled_r <= 4'h0;
		else if (settle_done)
			settled_r <= settled_r | (4'h1 << idx_r);
		else
			settled_r <= settled_r & en_nxt;
	end

	// ***************************************************************
	// outputs and diagnostics, all registered
	// ***************************************************************
	logic [rsft_pkg::TMR_W-1:0] since_r;
	logic                       range_bad;

	// delays outside the supported span, zero meaning no capacitor
	function automatic logic dly_bad(input logic [rsft_pkg::TMR_W-1:0] d);
		dly_bad = (d != '0) && (d < rsft_pkg::TMR_W'(rsft_pkg::DLY_MIN_CYC)
			|| d > rsft_pkg::TMR_W'(rsft_pkg::DLY_MAX_CYC));
	endfunction

	assign range_bad = dly_bad(step_dly_1) || dly_bad(step_dly_2)
		|| dly_bad(step_dly_3) || dly_bad(settle_dly)
		|| (!COMBINED && dly_bad(step_dly_0));

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rail_enable_outputs   <= 4'h0;
			chain_finished_output <= 1'b0;
			err_line_oe_n         <= 1'b0;
			err_line_out          <= 1'b0;
			fault_cause           <= 4'h0;
			since_r               <= '0;
			timer_recovering      <= 1'b1;
			delay_out_of_range    <= 1'b0;
		end
		else
		begin
			rail_enable_outputs   <= en_nxt;
			chain_finished_output <= st_nxt inside {rsft_pkg::RSFT_RAILS_ON,
				rsft_pkg::RSFT_DN_STEP, rsft_pkg::RSFT_DN_LAST};
			err_line_oe_n         <= !drive_err_nxt;
			err_line_out          <= 1'b0;
			if (any_fault)
				fault_cause <= {f_ext, f_edge, f_uv_up | f_uv_dn, f_settle};
			// timers need idle time to be trusted again after use
			since_r <= (|step_run || settle_run) ? '0 :
				(since_r >= RECOV_CYC ? since_r : since_r + 1'b1);
			timer_recovering   <= (since_r < RECOV_CYC);
			delay_out_of_range <= range_bad;
		end
	end

endmodule

// ==== rsft_seq_props.sv ====
`timescale 1ns/1ps
// ***************************************************************
// port checker for the rail sequencer
// ***************************************************************
module rsft_seq_props
#(
	parameter logic [31:0] HOLD_CYC = 32'h14
)
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic [3:0]  rail_sense_inputs,
	input wire logic        req_rise_in,
	input wire logic        req_fall_in,
	input wire logic        err_line_in,
	input wire logic [31:0] step_dly_1,
	input wire logic [31:0] settle_dly,
	input wire logic [3:0]  rail_enable_outputs,
	input wire logic        chain_finished_output,
	input wire logic        err_line_oe_n
);
	logic [31:0] low_cnt_r, pend_cnt_r, gap_cnt_r;
	logic [31:0] low_nxt, pend_nxt, gap_nxt;
	logic [3:0]  en_prev_r;

	// counters: cycles of own drive, of an enabled rail not up, of stable enables
	assign low_nxt  = err_line_oe_n ? 32'h0 : low_cnt_r + 32'h1;
	assign pend_nxt = (err_line_oe_n && |(rail_enable_outputs & ~rail_sense_inputs))
		? pend_cnt_r + 32'h1 : 32'h0;
	assign gap_nxt  = (rail_enable_outputs != en_prev_r) ? 32'h0 : gap_cnt_r + 32'h1;
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			low_cnt_r  <= 32'h0;
			pend_cnt_r <= 32'h0;
			gap_cnt_r  <= 32'h0;
			en_prev_r  <= 4'h0;
		end
		else
		begin
			low_cnt_r  <= low_nxt;
			pend_cnt_r <= pend_nxt;
			gap_cnt_r  <= gap_nxt;
			en_prev_r  <= rail_enable_outputs;
		end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// edge faults get sync latency plus one register, six cycles is ample
	start_in_fault_a: assert property ($rose(rst_n) |-> !err_line_oe_n && rail_enable_outputs == 4'h0)
		else $error("not in fault entry after reset");
	fault_all_off_a: assert property ($fell(err_line_oe_n) |-> rail_enable_outputs == 4'h0 && !chain_finished_output)
		else $error("fault left an output on");
	hold_min_a: assert property ($rose(err_line_oe_n) |-> low_cnt_r >= HOLD_CYC)
		else $error("error line released too early");
	req_extends_a: assert property ((req_rise_in && !err_line_oe_n) [*4] |=> !err_line_oe_n)
		else $error("error line released with request high");
	ext_fault_a: assert property ((!err_line_in) [*6] |-> rail_enable_outputs == 4'h0 && !chain_finished_output)
		else $error("low error line did not stop sequencing");
	settle_bound_a: assert property (settle_dly != 32'h0 |-> pend_cnt_r <= settle_dly + 32'h8)
		else $error("rail below level not faulted in time");
	up_gap_a: assert property ((rail_enable_outputs > en_prev_r) && en_prev_r != 4'h0 |-> gap_cnt_r >= settle_dly + step_dly_1)
		else $error("next rail enabled too early");
	down_gap_a: assert property ((rail_enable_outputs < en_prev_r) && rail_enable_outputs != 4'h0 |-> gap_cnt_r >= step_dly_1)
		else $error("rails disabled too close together");
	rise_on_fault_a: assert property ($rose(req_rise_in) && chain_finished_output && err_line_oe_n |-> ##[1:6] !err_line_oe_n)
		else $error("rising request in rails-on not faulted");
	fall_up_fault_a: assert property ($fell(req_fall_in) && rail_enable_outputs != 4'h0 && !chain_finished_output && err_line_oe_n |-> ##[1:6] !err_line_oe_n)
		else $error("falling request in power-up not faulted");

	cover property ($rose(chain_finished_output));
	cover property ($fell(chain_finished_output) && err_line_oe_n);
	cover property ($rose(err_line_oe_n) && !err_line_in);
endmodule

bind rsft_seq rsft_seq_props #(.HOLD_CYC(HOLD_CYC)) rsft_seq_props_inst (
	.core_clk(core_clk), .rst_n(rst_n), .rail_sense_inputs(rail_sense_inputs),
	.req_rise_in(req_rise_in), .req_fall_in(req_fall_in),
	.err_line_in(err_line_in), .step_dly_1(step_dly_1), .settle_dly(settle_dly),
	.rail_enable_outputs(rail_enable_outputs),
	.chain_finished_output(chain_finished_output), .err_line_oe_n(err_line_oe_n));

// ==== rsft_seq_test.sv ====
`timescale 1ns/1ps
// ***************************************************************
// self-checking bench for the rail sequencer
// ***************************************************************
module rsft_seq_test;
	localparam int HOLD = 32'h14;
	localparam int STEP = 32'ha;
	typedef struct packed {logic [1:0] act; logic [3:0] cause;} rsft_row_t;
	logic        core_clk, rst_n, req_rise_in, req_fall_in, ext_pull;
	logic [3:0]  kill, rail_sense_inputs, rail_enable_outputs, fault_cause;
	logic        err_line_in, chain_finished_output, err_line_oe_n;
	logic        err_line_out, timer_recovering, delay_out_of_range;
	logic [31:0] settle_dly, step_dly;
	int          n_mismatch, n_tests;
	// down sequence, rail drop, rising request, brief external pull
	rsft_row_t   rows [4] = '{'{2'h0, 4'h0}, '{2'h1, 4'h2}, '{2'h2, 4'h4}, '{2'h3, 4'h8}};

	rsft_seq #(.COMBINED(1'b0), .HOLD_CYC(HOLD), .QUAL_CYC(32'h4), .RECOV_CYC(32'h8))
	rsft_seq_inst (.core_clk(core_clk), .rst_n(rst_n),
		.rail_sense_inputs(rail_sense_inputs), .req_rise_in(req_rise_in),
		.req_fall_in(req_fall_in), .err_line_in(err_line_in),
		.step_dly_0(step_dly), .step_dly_1(step_dly), .step_dly_2(step_dly),
		.step_dly_3(step_dly), .settle_dly(settle_dly),
		.rail_enable_outputs(rail_enable_outputs),
		.chain_finished_output(chain_finished_output),
		.err_line_oe_n(err_line_oe_n), .err_line_out(err_line_out),
		.fault_cause(fault_cause), .timer_recovering(timer_recovering),
		.delay_out_of_range(delay_out_of_range));

	rsft_far_end #(.LAG(3)) rsft_far_end_inst (.core_clk(core_clk), .rst_n(rst_n),
		.rail_enable_outputs(rail_enable_outputs), .err_line_oe_n(err_line_oe_n),
		.err_line_out(err_line_out), .kill(kill), .ext_pull(ext_pull),
		.rail_sense_inputs(rail_sense_inputs), .err_line_in(err_line_in));

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		if (n_mismatch == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function automatic logic pick(input int sel);
		return sel == 0 ? err_line_oe_n : sel == 1 ? chain_finished_output : timer_recovering;
	endfunction

	// bounded wait on drive, finished or recovery flag; a timeout ends the run
	task automatic wait_for(input int sel, input logic v, input int lim);
		int i;
		i = 0;
		while (pick(sel) !== v && i < lim)
		begin
			@(negedge core_clk);
			i++;
		end
		if (pick(sel) !== v)
		begin
			chk1(pick(sel), v);
			final_report();
		end
	endtask

	// timers get time to recover before each new start
	task automatic power_up(input logic full);
		int i;
		wait_for(2, 1'b0, 100);
		// idle comes a few cycles after the line reads high again
		tick(4);
		req_rise_in <= 1'b1;
		i = 0;
		while (rail_enable_outputs === 4'h0 && i < 200)
		begin
			@(negedge core_clk);
			i++;
		end
		chk1(i >= STEP && i <= STEP + 10, 1'b1);
		if (i >= 200)
			final_report();
		if (full)
		begin
			wait_for(1, 1'b1, 400);
			chk4(rail_enable_outputs, 4'hf);
		end
	endtask

	task automatic recover(input int lim);
		wait_for(0, 1'b0, lim);
		chk4(rail_enable_outputs, 4'h0);
		chk1(chain_finished_output, 1'b0);
		chk1(err_line_out, 1'b0);
		tick(HOLD + 10);
		@(negedge core_clk);
		chk1(err_line_oe_n, 1'b0);
		tick(1);
		req_rise_in <= 1'b0;
		kill <= 4'h0;
		wait_for(0, 1'b1, 20);
	endtask

	initial
	begin
		rst_n = 1'b0;
		req_rise_in = 1'b0;
		req_fall_in = 1'b1;
		ext_pull = 1'b0;
		kill = 4'h0;
		settle_dly = 32'hc;
		step_dly = 32'ha;
		n_mismatch = 0;
		n_tests = 0;
		tick(4);
		@(negedge core_clk);
		chk4(rail_enable_outputs, 4'h0);
		chk1(err_line_oe_n, 1'b0);
		chk1(timer_recovering, 1'b1);
		tick(1);
		rst_n <= 1'b1;
		// request low from the start, so entry passes straight to line wait
		wait_for(0, 1'b1, HOLD + 40);
		chk1(delay_out_of_range, 1'b1);
		for (int k = 0; k < 4; k++)
		begin
			power_up(1'b1);
			tick(1);
			case (rows[k].act)
				2'h0:
				begin
					req_fall_in <= 1'b0;
					wait_for(1, 1'b0, 200);
					chk4(rail_enable_outputs, 4'h0);
					chk1(err_line_oe_n, 1'b1);
					tick(1);
					req_rise_in <= 1'b0;
					req_fall_in <= 1'b1;
				end
				2'h1:
				begin
					kill <= 4'h4;
					recover(20);
				end
				2'h2:
				begin
					req_rise_in <= 1'b0;
					tick(6);
					req_rise_in <= 1'b1;
					recover(20);
				end
				default:
				begin
					ext_pull <= 1'b1;
					tick(3);
					ext_pull <= 1'b0;
					recover(20);
				end
			endcase
			chk4(fault_cause, rows[k].cause);
		end
		// second rail never reaches its level
		tick(1);
		kill <= 4'h2;
		power_up(1'b0);
		recover(80);
		chk4(fault_cause, 4'h1);
		// falling request in mid power-up
		power_up(1'b0);
		tick(1);
		req_fall_in <= 1'b0;
		recover(20);
		chk4(fault_cause, 4'h4);
		tick(1);
		req_fall_in <= 1'b1;
		// another party keeps the line low: no start while it does
		power_up(1'b1);
		tick(1);
		ext_pull <= 1'b1;
		recover(20);
		tick(1);
		req_rise_in <= 1'b1;
		tick(30);
		@(negedge core_clk);
		chk4(rail_enable_outputs, 4'h0);
		chk4(fault_cause, 4'h8);
		tick(1);
		ext_pull <= 1'b0;
		req_rise_in <= 1'b0;
		tick(10);
		power_up(1'b1);
		// reset in mid-run lands in fault entry
		tick(1);
		rst_n <= 1'b0;
		tick(2);
		@(negedge core_clk);
		chk4(rail_enable_outputs, 4'h0);
		chk1(chain_finished_output, 1'b0);
		chk1(err_line_oe_n, 1'b0);
		tick(1);
		rst_n <= 1'b1;
		req_rise_in <= 1'b0;
		wait_for(0, 1'b1, HOLD + 40);
		// range flag: zero means no capacitor, lower edge of the span
		tick(1);
		settle_dly <= 32'h0;
		step_dly <= 32'h0;
		tick(4);
		chk1(delay_out_of_range, 1'b0);
		settle_dly <= 32'h1e848;
		tick(4);
		chk1(delay_out_of_range, 1'b0);
		settle_dly <= 32'h1e847;
		tick(4);
		chk1(delay_out_of_range, 1'b1);
		final_report();
	end
endmodule

// ==== rsft_sync.sv ====
`timescale 1ns/1ps
// ***************************************************************
// two-stage synchroniser with one-event edge outputs
// ***************************************************************
module rsft_sync
#(
	parameter int unsigned W = 1
)
(
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	input  wire logic [W-1:0] rst_val,
	output logic      [W-1:0] sync_out,
	output logic      [W-1:0] rise_out,
	output logic      [W-1:0] fall_out
);

	logic [W-1:0] meta_r;
	logic [W-1:0] stab_r;
	logic [W-1:0] prev_r;
	logic         armed_r;

	// first stage feeds only the second
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			stab_r <= '0;
		end
		else
		begin
			meta_r <= async_in;
			stab_r <= meta_r;
		end
	end

	// history starts from the strap-free reset level, armed after one edge
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_r  <= '0;
			armed_r <= 1'b0;
		end
		else
		begin
			prev_r  <= armed_r ? stab_r : rst_val;
			armed_r <= 1'b1;
		end
	end

	// edges are taken on stable samples so each transition fires once
	assign sync_out = stab_r;
	assign rise_out = armed_r ? (stab_r & ~prev_r) : '0;
	assign fall_out = armed_r ? (~stab_r & prev_r) : '0;

endmodule

// ==== rsft_timer.sv ====
`timescale 1ns/1ps
// ***************************************************************
// programmable delay timer, stands in for one timing capacitor
// ***************************************************************
module rsft_timer
#(
	parameter int unsigned TW = rsft_pkg::TMR_W
)
(
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	input  wire logic          run,
	input  wire logic [TW-1:0] limit,
	output logic               done
);

	logic [TW-1:0] cnt_r;
	logic [TW-1:0] cnt_nxt;
	logic          hit;

	// a zero limit behaves like a missing capacitor: minimal delay
	assign hit     = (limit == '0) ? (cnt_r >= TW'(rsft_pkg::NOCAP_CYC))
		: (cnt_r >= limit);
	assign cnt_nxt = hit ? cnt_r : cnt_r + TW'(1);

	// cleared whenever idle, so every use restarts from zero
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= '0;
		else
			cnt_r <= run ? cnt_nxt : '0;
	end

	assign done = run && hit;

endmodule
